// >>> verification/waveform_deadband_shutdown_ctl_test.sv
`timescale 1ns/10ps
module waveform_deadband_shutdown_ctl_test;
	// ==========================================================
	// stimulus and observation
	logic                           aclk           = 1'h0;
	logic                           aresetn        = 1'h0;
	logic                           awvalid        = 1'h0;
	logic                           wvalid         = 1'h0;
	logic                           bready         = 1'h0;
	logic                           arvalid        = 1'h0;
	logic                           rready         = 1'h0;
	logic [wds_pkg::AXI_ADDR_W-1:0] awaddr         = 8'h00;
	logic [wds_pkg::AXI_ADDR_W-1:0] araddr         = 8'h00;
	logic [31:0]                    wdata          = 32'h0;
	logic [2:0]                     prot           = 3'h0;
	logic [3:0]                     wstrb          = 4'hF;
	logic                           wave_in        = 1'h0;
	logic                           shutdown_event = 1'h0;
	logic                           awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]                     bresp, rresp, last_resp;
	logic [31:0]                    rdata;
	logic [3:0]                     wave_out, wave_oe, gate_level;
	logic                           shoot;
	int                             bad_count      = 0;
	int                             total_checks   = 0;
	int                             shoot_cnt      = 0;
	int                             cyc            = 0;

	always #4 aclk = ~aclk;

	wds_ctl DUT (
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(prot),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(prot),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.wave_in(wave_in), .shutdown_event(shutdown_event),
		.wave_out(wave_out), .wave_oe(wave_oe), .irq(irq)
	);

	wds_switch_model GATES (
		.gate(wave_out), .gate_oe(wave_oe), .gate_level(gate_level), .shoot(shoot)
	);

	// ==========================================================
	// reporting
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// whole run needs about 700 cycles; the ceiling leaves margin for slow answers
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (shoot === 1'h1) shoot_cnt <= shoot_cnt + 1;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end

	// ==========================================================
	// register bus and input stimulus
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		do begin
			@(posedge aclk);
			if (awvalid && awready === 1'h1) awvalid <= 1'h0;
			if (wvalid && wready === 1'h1) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		last_resp = bresp;
		bready <= 1'h0;
	endtask : axw

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		do begin
			@(posedge aclk);
			if (arvalid && arready === 1'h1) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		last_resp = rresp;
		rready <= 1'h0;
		chk(rdata, exp);
	endtask : chk_rd

	task automatic pulse_event;
		@(posedge aclk);
		shutdown_event <= 1'h1;
		@(posedge aclk);
		shutdown_event <= 1'h0;
	endtask : pulse_event

	// edge on the input, then cycles until pin idx reaches tgt
	task automatic lat(input logic v, input int idx, input logic tgt, output int n);
		@(posedge aclk);
		wave_in <= v;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (wave_out[idx] !== tgt && n < 200);
		repeat (80) @(posedge aclk);
	endtask : lat

	// ==========================================================
	// scenarios
	task automatic t_reset;
		chk(wave_oe, 32'hF);
		chk(irq, 32'h0);
		chk_rd(8'h04, 32'h0);
		chk_rd(8'h08, 32'h0);
		chk_rd(8'h0C, 32'h14);
		chk_rd(8'h14, 32'h0);
		chk_rd(8'h18, 32'h0);
		chk(last_resp, wds_pkg::RESP_SLVERR);
		axw(8'h18, 32'hFF);
		chk(last_resp, wds_pkg::RESP_SLVERR);
	endtask : t_reset

	task automatic t_width;
		axw(8'h04, 32'hFFFFFFFF);
		chk(last_resp, wds_pkg::RESP_OKAY);
		chk_rd(8'h04, 32'h3F);
		// a write with the low strobe clear stores nothing but still answers okay
		wstrb <= 4'h0;
		axw(8'h04, 32'h00000011);
		wstrb <= 4'hF;
		chk(last_resp, wds_pkg::RESP_OKAY);
		chk_rd(8'h04, 32'h3F);
		axw(8'h08, 32'hFFFFFFC0);
		chk_rd(8'h08, 32'h0);
	endtask : t_width

	task automatic t_deadband;
		int r0, f0, r1, f1, s0;
		s0 = shoot_cnt;
		axw(8'h04, 32'h0);
		axw(8'h08, 32'h0);
		lat(1'h1, 0, 1'h1, r0);
		lat(1'h0, 1, 1'h1, f0);
		axw(8'h04, 32'h3F);
		axw(8'h08, 32'h09);
		lat(1'h1, 0, 1'h1, r1);
		lat(1'h0, 1, 1'h1, f1);
		chk(r1 - r0, 63);
		chk(f1 - f0, 9);
		chk(shoot_cnt - s0, 0);
	endtask : t_deadband

	task automatic t_polarity;
		chk(wave_out, 32'hA);
		axw(8'h00, 32'hF);
		repeat (4) @(posedge aclk);
		chk(wave_out, 32'h5);
		axw(8'h00, 32'h2);
		repeat (4) @(posedge aclk);
		chk(wave_out, 32'h8);
		chk_rd(8'h00, 32'h2);
	endtask : t_polarity

	task automatic t_shutdown;
		logic [3:0] eo, ee;
		axw(8'h00, 32'h0);
		axw(8'h0C, 32'h28);
		pulse_event();
		repeat (4) @(posedge aclk);
		chk(wave_out, 32'h0);
		chk(wave_oe, 32'hF);
		chk(irq, 32'h0);
		chk_rd(8'h0C, 32'hA8);
		axw(8'h14, 32'h1);
		repeat (2) @(posedge aclk);
		chk(irq, 32'h1);
		axw(8'h10, 32'h1);
		repeat (2) @(posedge aclk);
		chk(irq, 32'h0);
		axw(8'h00, 32'h5);
		// flag written to one forces the shut state for each pin code
		for (int c = 0; c < 4; c++) begin
			case (c)
				0: begin eo = 4'h5; ee = 4'hF; end
				1: begin eo = 4'h0; ee = 4'h0; end
				2: begin eo = 4'h0; ee = 4'hF; end
				default: begin eo = 4'hF; ee = 4'hF; end
			endcase
			axw(8'h0C, 32'h80 | (c << 4) | (c << 2));
			repeat (3) @(posedge aclk);
			chk(wave_out, eo);
			chk(wave_oe, ee);
		end
	endtask : t_shutdown

	task automatic t_resume;
		axw(8'h00, 32'h0);
		axw(8'h0C, 32'h28);
		axw(8'h10, 32'h3);
		repeat (6) @(posedge aclk);
		chk(wave_out, 32'h0);
		chk(wave_oe, 32'hF);
		@(posedge aclk);
		wave_in <= 1'h1;
		repeat (80) @(posedge aclk);
		chk(wave_out, 32'h5);
		chk_rd(8'h00, 32'h20);
		chk_rd(8'h10, 32'h2);
		@(posedge aclk);
		wave_in <= 1'h0;
		repeat (20) @(posedge aclk);
	endtask : t_resume

	task automatic t_restart;
		axw(8'h0C, 32'h68);
		axw(8'h10, 32'h3);
		pulse_event();
		repeat (4) @(posedge aclk);
		chk_rd(8'h0C, 32'h68);
		chk_rd(8'h10, 32'h1);
		chk(wave_out, 32'h0);
	endtask : t_restart

	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (3) @(posedge aclk);
		t_reset();
		t_width();
		t_deadband();
		t_polarity();
		t_shutdown();
		t_resume();
		t_restart();
		final_report();
	end
endmodule : waveform_deadband_shutdown_ctl_test

// >>> verification/wds_switch_model.sv
`timescale 1ns/10ps
// ==========================================================
// gate drivers of the power stage fed by the four pins
module wds_switch_model (
	// pins from the block
	input  wire logic [3:0] gate,
	input  wire logic [3:0] gate_oe,
	// resolved gate levels and overlap flag
	output logic      [3:0] gate_level,
	output logic            shoot
);
	// driver inputs carry pull-downs, so a released pin reads low
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			gate_level[i] = (gate_oe[i] === 1'h1) ? gate[i] : 1'h0;
		end
		// high and low switch of leg one conducting together
		shoot = gate_level[0] & gate_level[1];
	end
endmodule : wds_switch_model

// >>> verilog/wds_ctl.sv
`timescale 1ns/10ps
module wds_ctl (
	// clock and reset
	input  logic                          aclk,
	input  logic                          aresetn,
	// axi4-lite write address
	input  logic                          awvalid,
	output logic                          awready,
	input  logic [wds_pkg::AXI_ADDR_W-1:0] awaddr,
	input  logic [2:0]                    awprot,
	// axi4-lite write data
	input  logic                          wvalid,
	output logic                          wready,
	input  logic [31:0]                   wdata,
	input  logic [3:0]                    wstrb,
	// axi4-lite write response
	output logic                          bvalid,
	input  logic                          bready,
	output logic [1:0]                    bresp,
	// axi4-lite read
	input  logic                          arvalid,
	output logic                          arready,
	input  logic [wds_pkg::AXI_ADDR_W-1:0] araddr,
	input  logic [2:0]                    arprot,
	output logic                          rvalid,
	input  logic                          rready,
	output logic [31:0]                   rdata,
	output logic [1:0]                    rresp,
	// waveform and shutdown source
	input  logic                          wave_in,
	input  logic                          shutdown_event,
	// output pins
	output logic [wds_pkg::NUM_OUT-1:0]   wave_out,
	output logic [wds_pkg::NUM_OUT-1:0]   wave_oe,
	// interrupt
	output logic                          irq
);
	// ==========================================================
	// state
	logic [wds_pkg::NUM_OUT-1:0]  pol_q, pol_d;
	logic [wds_pkg::DB_BITS-1:0]  rise_q, rise_d;
	logic [wds_pkg::DB_BITS-1:0]  fall_q, fall_d;
	logic                         sd_q, sd_d;
	logic                         ren_q, ren_d;
	logic [1:0]                   pair_bd_q, pair_bd_d;
	logic [1:0]                   pair_ac_q, pair_ac_d;
	logic [wds_pkg::IRQ_BITS-1:0] ists_q, ists_d;
	logic [wds_pkg::IRQ_BITS-1:0] imask_q, imask_d;
	logic                         act_q, act_d;
	logic                         wave_p_q;
	logic                         irq_q, irq_d;
	logic                         awr_q, awr_d;
	logic                         wr_q, wr_d;
	logic                         awh_q, awh_d;
	logic                         wh_q, wh_d;
	logic [7:0]                   awa_q, awa_d;
	logic [31:0]                  wd_q, wd_d;
	logic                         ws_q, ws_d;
	logic                         bv_q, bv_d;
	logic [1:0]                   br_q, br_d;
	logic                         arr_q, arr_d;
	logic                         rv_q, rv_d;
	logic [31:0]                  rd_q, rd_d;
	logic [1:0]                   rr_q, rr_d;

	logic                         do_wr;
	logic                         wr_asd;
	logic                         wave_rise;
	logic                         ev_enter;
	logic                         ev_resume;
	logic [wds_pkg::NUM_OUT-1:0]  raw;
	logic                         rise_db;
	logic                         fall_db;

	assign wave_rise = wave_in & ~wave_p_q;
	assign do_wr     = awh_q & wh_q & ~bv_q;
	assign wr_asd    = do_wr & ws_q & (awa_q == wds_pkg::OFF_AUTOSD);

	// ==========================================================
	// bus and register next state
	always_comb begin
		pol_d   = pol_q;
		rise_d  = rise_q;
		fall_d  = fall_q;
		ren_d   = ren_q;
		pair_bd_d = pair_bd_q;
		pair_ac_d = pair_ac_q;
		imask_d = imask_q;
		awh_d   = awh_q;
		wh_d    = wh_q;
		awa_d   = awa_q;
		wd_d    = wd_q;
		ws_d    = ws_q;
		bv_d    = bv_q;
		br_d    = br_q;
		rv_d    = rv_q;
		rd_d    = rd_q;
		rr_d    = rr_q;
		sd_d    = sd_q;
		ists_d  = ists_q;
		// address and data taken in either order
		if (awvalid && awr_q) begin
			awh_d = 1'b1;
			awa_d = awaddr[7:0];
		end
		if (wvalid && wr_q) begin
			wh_d = 1'b1;
			wd_d = wdata;
			ws_d = wstrb[0];
		end
		if (bv_q && bready) begin
			bv_d = 1'b0;
		end
		if (do_wr) begin
			awh_d = 1'b0;
			wh_d  = 1'b0;
			bv_d  = 1'b1;
			br_d  = wds_pkg::RESP_OKAY;
			case (awa_q)
				wds_pkg::OFF_WAVE_CTL1: if (ws_q) pol_d = wd_q[wds_pkg::NUM_OUT-1:0];
				wds_pkg::OFF_RISE_DB:   if (ws_q) rise_d = wd_q[wds_pkg::DB_BITS-1:0];
				wds_pkg::OFF_FALL_DB:   if (ws_q) fall_d = wd_q[wds_pkg::DB_BITS-1:0];
				wds_pkg::OFF_AUTOSD: begin
					if (ws_q) begin
						sd_d   = wd_q[wds_pkg::POS_SHUTDOWN];
						ren_d  = wd_q[wds_pkg::POS_RESTART];
						pair_bd_d = wd_q[wds_pkg::POS_PAIR_BD +: 2];
						pair_ac_d = wd_q[wds_pkg::POS_PAIR_AC +: 2];
					end
				end
				wds_pkg::OFF_IRQ_STS:   if (ws_q) ists_d = ists_q & ~wd_q[wds_pkg::IRQ_BITS-1:0];
				wds_pkg::OFF_IRQ_MASK:  if (ws_q) imask_d = wd_q[wds_pkg::IRQ_BITS-1:0];
				default:                br_d = wds_pkg::RESP_SLVERR;
			endcase
		end
		// restart once the event has gone, unless software writes the auto-shutdown register this cycle
		if (sd_q && ren_q && !shutdown_event && !wr_asd) begin
			sd_d = 1'b0;
		end
		// hardware set wins over any clear
		if (shutdown_event) begin
			sd_d = 1'b1;
		end
		if (rv_q && rready) begin
			rv_d = 1'b0;
		end
		if (arvalid && arr_q) begin
			rv_d = 1'b1;
			rd_d = '0;
			rr_d = wds_pkg::RESP_OKAY;
			case (araddr[7:0])
				wds_pkg::OFF_WAVE_CTL1: begin
					rd_d[wds_pkg::NUM_OUT-1:0]   = pol_q;
					rd_d[wds_pkg::POS_IN_VALUE] = wave_in;
				end
				wds_pkg::OFF_RISE_DB:   rd_d[wds_pkg::DB_BITS-1:0] = rise_q;
				wds_pkg::OFF_FALL_DB:   rd_d[wds_pkg::DB_BITS-1:0] = fall_q;
				wds_pkg::OFF_AUTOSD: begin
					rd_d[wds_pkg::POS_SHUTDOWN]    = sd_q;
					rd_d[wds_pkg::POS_RESTART]     = ren_q;
					rd_d[wds_pkg::POS_PAIR_BD +: 2] = pair_bd_q;
					rd_d[wds_pkg::POS_PAIR_AC +: 2] = pair_ac_q;
				end
				wds_pkg::OFF_IRQ_STS:   rd_d[wds_pkg::IRQ_BITS-1:0] = ists_q;
				wds_pkg::OFF_IRQ_MASK:  rd_d[wds_pkg::IRQ_BITS-1:0] = imask_q;
				default:                rr_d = wds_pkg::RESP_SLVERR;
			endcase
		end
		// a shut output holds until the first input rise after the flag drops
		act_d     = sd_q | (act_q & ~wave_rise);
		ev_enter  = sd_d & ~sd_q;
		ev_resume = act_q & ~act_d;
		// set wins over write-one-to-clear
		ists_d[wds_pkg::IRQ_SD_ENTER] = ists_d[wds_pkg::IRQ_SD_ENTER] | ev_enter;
		ists_d[wds_pkg::IRQ_RESUME]   = ists_d[wds_pkg::IRQ_RESUME] | ev_resume;
		irq_d = |(ists_q & imask_q);
		awr_d = ~awh_d & ~bv_d;
		wr_d  = ~wh_d & ~bv_d;
		arr_d = ~rv_d;
	end

	// ==========================================================
	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pol_q    <= wds_pkg::RST_POLARITY;
			rise_q   <= wds_pkg::RST_DB;
			fall_q   <= wds_pkg::RST_DB;
			sd_q     <= wds_pkg::RST_SHUTDOWN;
			ren_q    <= wds_pkg::RST_RESTART;
			pair_bd_q <= wds_pkg::RST_PAIR;
			pair_ac_q <= wds_pkg::RST_PAIR;
			ists_q   <= '0;
			imask_q  <= wds_pkg::RST_IRQ_MASK;
			act_q    <= 1'b0;
			wave_p_q <= 1'b0;
			irq_q    <= 1'b0;
			awr_q    <= 1'b0;
			wr_q     <= 1'b0;
			awh_q    <= 1'b0;
			wh_q     <= 1'b0;
			awa_q    <= '0;
			wd_q     <= '0;
			ws_q     <= 1'b0;
			bv_q     <= 1'b0;
			br_q     <= wds_pkg::RESP_OKAY;
			arr_q    <= 1'b0;
			rv_q     <= 1'b0;
			rd_q     <= '0;
			rr_q     <= wds_pkg::RESP_OKAY;
		end else begin
			pol_q    <= pol_d;
			rise_q   <= rise_d;
			fall_q   <= fall_d;
			sd_q     <= sd_d;
			ren_q    <= ren_d;
			pair_bd_q <= pair_bd_d;
			pair_ac_q <= pair_ac_d;
			ists_q   <= ists_d;
			imask_q  <= imask_d;
			act_q    <= act_d;
			wave_p_q <= wave_in;
			irq_q    <= irq_d;
			awr_q    <= awr_d;
			wr_q     <= wr_d;
			awh_q    <= awh_d;
			wh_q     <= wh_d;
			awa_q    <= awa_d;
			wd_q     <= wd_d;
			ws_q     <= ws_d;
			bv_q     <= bv_d;
			br_q     <= br_d;
			arr_q    <= arr_d;
			rv_q     <= rv_d;
			rd_q     <= rd_d;
			rr_q     <= rr_d;
		end
	end

	assign awready = awr_q;
	assign wready  = wr_q;
	assign bvalid  = bv_q;
	assign bresp   = br_q;
	assign arready = arr_q;
	assign rvalid  = rv_q;
	assign rdata   = rd_q;
	assign rresp   = rr_q;
	assign irq     = irq_q;

	// ==========================================================
	// dead-band and output steering
	// the complement leg is the same delay unit fed the inverted input
	wds_deadband #(.W(wds_pkg::DB_BITS)) u_rise_db (
		.aclk    (aclk),
		.aresetn (aresetn),
		.level   (wave_in),
		.count   (rise_q),
		.delayed (rise_db)
	);
	wds_deadband #(.W(wds_pkg::DB_BITS)) u_fall_db (
		.aclk    (aclk),
		.aresetn (aresetn),
		.level   (~wave_in),
		.count   (fall_q),
		.delayed (fall_db)
	);

	// half-bridge pairing only; c and d mirror a and b
	assign raw = {fall_db, rise_db, fall_db, rise_db};

	wds_out_stage #(.N(wds_pkg::NUM_OUT)) u_out (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.raw      (raw),
		.invert   (pol_q),
		.shut     (act_q),
		.state_ac (pair_ac_q),
		.state_bd (pair_bd_q),
		.pin_out  (wave_out),
		.pin_oe   (wave_oe)
	);

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_sd_set;
		shutdown_event |=> sd_q;
	endproperty
	a_sd_set: assert property (p_sd_set) else $error("shutdown flag missed event");
	property p_restart;
		sd_q && ren_q && !shutdown_event && !wr_asd |=> !sd_q;
	endproperty
	a_restart: assert property (p_restart) else $error("auto-restart did not clear");
	property p_no_restart;
		sd_q && !ren_q && !wr_asd |=> sd_q;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("flag cleared without restart");
	property p_hold;
		$fell(sd_q) && !wave_rise |=> act_q;
	endproperty
	a_hold: assert property (p_hold) else $error("outputs resumed before input rise");
	property p_resume;
		act_q && !sd_q && wave_rise |=> !act_q ##1 (act_q == $past(sd_q));
	endproperty
	a_resume: assert property (p_resume) else $error("outputs not resumed on rise");
	property p_db_read;
		arvalid && arr_q && ((araddr == wds_pkg::OFF_RISE_DB) || (araddr == wds_pkg::OFF_FALL_DB))
			|=> rv_q && (rd_q[31:wds_pkg::DB_BITS] == '0);
	endproperty
	a_db_read: assert property (p_db_read) else $error("dead-band upper bits not zero");
	property p_irq;
		(|(ists_q & imask_q)) |=> irq_q;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");
	property p_bhold;
		bv_q && !bready |=> bv_q && $stable(br_q);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule : wds_ctl

// >>> verilog/wds_deadband.sv
`timescale 1ns/10ps
module wds_deadband #(
	parameter int W = 6
) (
	// clock and reset
	input  logic         aclk,
	input  logic         aresetn,
	// edge to delay
	input  logic         level,
	input  logic [W-1:0] count,
	output logic         delayed
);
	// ==========================================================
	// counter
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         out_q;
	logic         out_d;

	always_comb begin
		cnt_d = cnt_q;
		out_d = out_q;
		if (!level) begin
			// reload while low so the edge uses the latest value
			cnt_d = count;
			out_d = 1'b0;
		end else if (cnt_q == '0) begin
			out_d = 1'b1;
		end else begin
			cnt_d = W'(cnt_q - 1'b1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign delayed = out_q;

	// ==========================================================
	// checks
	property p_db_rise;
		@(posedge aclk) disable iff (!aresetn)
		$rose(out_q) |-> $past(level) && ($past(cnt_q) == '0);
	endproperty
	a_db_rise: assert property (p_db_rise) else $error("edge left before count ran out");
	property p_db_low;
		@(posedge aclk) disable iff (!aresetn)
		!level |=> !out_q;
	endproperty
	a_db_low: assert property (p_db_low) else $error("output high while level low");
endmodule : wds_deadband

// >>> verilog/wds_out_stage.sv
`timescale 1ns/10ps
module wds_out_stage #(
	parameter int N = 4
) (
	// clock and reset
	input  logic         aclk,
	input  logic         aresetn,
	// steering
	input  logic [N-1:0] raw,
	input  logic [N-1:0] invert,
	input  logic         shut,
	input  logic [1:0]   state_ac,
	input  logic [1:0]   state_bd,
	// pins
	output logic [N-1:0] pin_out,
	output logic [N-1:0] pin_oe
);
	// ==========================================================
	// per pin output flop
	for (genvar i = 0; i < N; i++) begin : g_pin
		logic       o_q;
		logic       o_d;
		logic       e_q;
		logic       e_d;
		logic [1:0] sel;

		assign sel = (i % 2 == 0) ? state_ac : state_bd;

		always_comb begin
			o_d = raw[i] ^ invert[i];
			e_d = 1'b1;
			if (shut) begin
				case (sel)
					wds_pkg::SDS_HIGH:     o_d = 1'b1;
					wds_pkg::SDS_LOW:      o_d = 1'b0;
					wds_pkg::SDS_TRISTATE: begin
						o_d = 1'b0;
						e_d = 1'b0;
					end
					default:               o_d = invert[i];
				endcase
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				o_q <= 1'b0;
				e_q <= 1'b0;
			end else begin
				o_q <= o_d;
				e_q <= e_d;
			end
		end

		assign pin_out[i] = o_q;
		assign pin_oe[i]  = e_q;

		// an attempt on the last reset edge would still see the reset enable
		property p_pol;
			@(posedge aclk) disable iff (!aresetn)
			aresetn && !shut |=> (o_q == ($past(raw[i]) ^ $past(invert[i]))) && e_q;
		endproperty
		a_pol: assert property (p_pol) else $error("polarity not applied");
		property p_force;
			@(posedge aclk) disable iff (!aresetn)
			shut && (sel == wds_pkg::SDS_TRISTATE) |=> !e_q ##1 (!shut || e_q || !o_q);
		endproperty
		a_force: assert property (p_force) else $error("tristate state not released");
		property p_high;
			@(posedge aclk) disable iff (!aresetn)
			shut && (sel == wds_pkg::SDS_HIGH) |=> o_q && e_q;
		endproperty
		a_high: assert property (p_high) else $error("forced high not driven");
	end
endmodule : wds_out_stage

// >>> verilog/wds_pkg.sv
package wds_pkg;
	// ==========================================================
	// bus geometry
	localparam int         AXI_ADDR_W   = 8;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_WAVE_CTL1 = 8'h00;
	localparam logic [7:0] OFF_RISE_DB   = 8'h04;
	localparam logic [7:0] OFF_FALL_DB   = 8'h08;
	localparam logic [7:0] OFF_AUTOSD    = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STS   = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;

	// ==========================================================
	// field positions and widths
	localparam int NUM_OUT      = 4;
	localparam int DB_BITS      = 6;
	localparam int POS_IN_VALUE = 5;
	localparam int POS_SHUTDOWN = 7;
	localparam int POS_RESTART  = 6;
	localparam int POS_PAIR_BD  = 4;
	localparam int POS_PAIR_AC  = 2;
	localparam int IRQ_BITS     = 2;
	localparam int IRQ_SD_ENTER = 0;
	localparam int IRQ_RESUME   = 1;

	// ==========================================================
	// reset values
	localparam logic [3:0] RST_POLARITY = 4'h0;
	localparam logic [5:0] RST_DB       = 6'h00;
	localparam logic       RST_SHUTDOWN = 1'b0;
	localparam logic       RST_RESTART  = 1'b0;
	localparam logic [1:0] RST_PAIR     = 2'h1;
	localparam logic [1:0] RST_IRQ_MASK = 2'h0;

	// ==========================================================
	// shutdown pin states
	localparam logic [1:0] SDS_INACTIVE = 2'h0;
	localparam logic [1:0] SDS_TRISTATE = 2'h1;
	localparam logic [1:0] SDS_LOW      = 2'h2;
	localparam logic [1:0] SDS_HIGH     = 2'h3;
endpackage : wds_pkg
